// ---- hw/crystal_edge_sync.v ----
// synchroniser and rising-edge detector for the crystal oscillator input
`timescale 1ns/1ps

module crystal_edge_sync (
  input wire clock,
  input wire reset,
  input wire crystalInputClock,
  output wire risingEdge
);

  // ========================================================================
  // three-stage capture
  reg sync1_ff;
  reg sync2_ff;
  reg sync3_ff;
  reg level_ff;

  // the first stage feeds only the second, to keep metastability contained
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      sync1_ff <= crystalInputClock;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      // accept a new level only once stages two and three agree
      if (sync2_ff == sync3_ff) begin
        level_ff <= sync3_ff;
      end
    end
  end

  // one pulse per accepted low-to-high change
  assign risingEdge = (sync2_ff == sync3_ff) & sync3_ff & ~level_ff;

endmodule

// ---- hw/oscillator_prescaled_watchdog.v ----
// watchdog top: apb register file, countdown, chip reset trigger and interrupt
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "watchdog_regs.vh"

// ==========================================================================
// Contract
// R1: after reset neither counting nor triggering
// R2: control bit 0 enables countdown decrement
// R3: control bit 1 allows chip reset
// R4: software sets both bits for watchdog use
// R5: count-only mode causes no reset
// R6: prescaler counts oscillator edges, read-only
// R7: prescaler wraps to zero, steps countdown
// R8: limit field 16 bits, resets all ones
// R9: countdown 12 bits, resets all ones, decrements
// R10: zero with trigger enabled resets chip
// R11: software rewrites countdown before zero
// R12: status bit 0 set on trigger
// R13: status bit cleared only by power-on
// R14: count-only countdown holds at zero
// R15: stopped prescaler holds; countdown writes immediate

module oscillator_prescaled_watchdog (
  input wire clock,
  input wire reset,
  input wire porReset,
  input wire crystalInputClock,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire chipResetRequest,
  output wire irq
);

  // ========================================================================
  // helper functions

  // true when the byte address selects the register with this index
  function hitReg;
    input [17:0] addr;
    input [15:0] idx;
    begin
      hitReg = (addr == {idx, 2'b00});
    end
  endfunction

  // merge the two low byte lanes of a write into a 16-bit field
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      merge16 = old;
      if (strb[0]) begin
        merge16[7:0] = data[7:0];
      end
      if (strb[1]) begin
        merge16[15:8] = data[15:8];
      end
    end
  endfunction

  // true when the countdown has run out
  function countIsZero;
    input [11:0] cnt;
    begin
      countIsZero = (cnt == 12'h000);
    end
  endfunction

  // ========================================================================
  // state

  reg ctlRun_ff;
  reg ctlTrig_ff;
  reg [15:0] limit_ff;
  reg [11:0] count_ff;
  reg trigFlag_ff;
  reg chipReset_ff;
  reg [1:0] irqStatus_ff;
  reg [1:0] irqMask_ff;
  reg [31:0] prdata_ff;

  reg [11:0] nxt_count;
  reg [15:0] nxt_limit;
  reg [1:0] nxt_irqStatus;
  reg [31:0] nxt_prdata;
  reg [1:0] nxt_irqMask;
  reg [15:0] countMerged;

  wire oscEdge;
  wire [15:0] prescaleValue;
  wire prescaleStep;

  // ========================================================================
  // oscillator edge detection and prescaler

  // three clocks of latency; the oscillator must stay below a quarter of the
  // system clock or edges are lost
  crystal_edge_sync u_edge (
    .clock(clock),
    .reset(reset),
    .crystalInputClock(crystalInputClock),
    .risingEdge(oscEdge)
  );

  // the prescaler only runs while the countdown is enabled; a limit lowered
  // below the current value lets the count run on through its natural wrap
  // before the next step; stopping freezes the value, so lower the limit only while the value is at or below it
  watchdog_prescaler u_prescaler (
    .clock(clock),
    .reset(reset),
    .run(ctlRun_ff),
    .advance(oscEdge),
    .limit(limit_ff),
    .value(prescaleValue),
    .wrapStep(prescaleStep)
  );

  // ========================================================================
  // apb decode

  wire setupPhase;
  wire accessPhase;
  wire writeAccess;
  wire hitControl;
  wire hitValue;
  wire hitLimit;
  wire hitCount;
  wire hitFlag;
  wire hitIrqStatus;
  wire hitIrqMask;
  wire mapped;
  wire controlWrite;
  wire limitWrite;
  wire countWrite;
  wire statusWrite;
  wire maskWrite;

  assign setupPhase = psel & ~penable;
  assign accessPhase = psel & penable;
  assign writeAccess = accessPhase & pwrite;

  assign hitControl = hitReg(paddr, `WDG_IDX_CONTROL);
  assign hitValue = hitReg(paddr, `WDG_IDX_PRESCALE_VALUE);
  assign hitLimit = hitReg(paddr, `WDG_IDX_PRESCALE_LIMIT);
  assign hitCount = hitReg(paddr, `WDG_IDX_COUNTDOWN);
  assign hitFlag = hitReg(paddr, `WDG_IDX_TRIGGER_FLAG);
  assign hitIrqStatus = hitReg(paddr, `WDG_IDX_IRQ_STATUS);
  assign hitIrqMask = hitReg(paddr, `WDG_IDX_IRQ_MASK);

  // write strobes; bit registers need lane 0, the limit and count merge lanes
  assign controlWrite = writeAccess & hitControl & pstrb[0];
  assign limitWrite = writeAccess & hitLimit;
  assign countWrite = writeAccess & hitCount;
  assign statusWrite = writeAccess & hitIrqStatus & pstrb[0];
  assign maskWrite = writeAccess & hitIrqMask & pstrb[0];

  assign mapped = hitControl | hitValue | hitLimit | hitCount |
                  hitFlag | hitIrqStatus | hitIrqMask;

  // zero-wait slave; read data was latched in the setup cycle
  assign pready = 1'b1;
  assign pslverr = accessPhase & ~mapped;
  assign prdata = prdata_ff;

  // ========================================================================
  // events

  wire countStep;
  wire reachZero;
  wire fire;

  // one decrement per completed prescaler period; a parked zero never wraps round
  assign countStep = ctlRun_ff & prescaleStep & ~countIsZero(count_ff); // R2 R9 R14

  // countdown steps from one to zero on this cycle; a kick in the same cycle wins
  assign reachZero = countStep & ~countWrite & (count_ff == 12'h001);

  // armed and at zero: pull the chip reset; independent of the run bit, so
  // writing zero with the trigger armed fires at once
  assign fire = ctlTrig_ff & countIsZero(count_ff); // R3 R10

  // ========================================================================
  // control register

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ctlRun_ff <= 1'b0; // R1
      ctlTrig_ff <= 1'b0; // R1
    end else if (controlWrite) begin
      ctlRun_ff <= pwdata[`WDG_CTL_RUN_BIT]; // R2 R5
      ctlTrig_ff <= pwdata[`WDG_CTL_TRIG_BIT]; // R3 R5
    end
  end

  // ========================================================================
  // prescaler limit

  always @* begin
    nxt_limit = limit_ff;
    if (limitWrite) begin
      nxt_limit = merge16(limit_ff, pwdata, pstrb); // R8
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      limit_ff <= `WDG_LIMIT_RESET; // R8
    end else begin
      limit_ff <= nxt_limit;
    end
  end

  // ========================================================================
  // countdown

  // a software write wins over a step in the same cycle so a kick is
  // never lost; at zero the count parks until rewritten
  always @* begin
    countMerged = merge16({4'h0, count_ff}, pwdata, pstrb);
    nxt_count = count_ff; // R14
    if (countWrite) begin
      nxt_count = countMerged[`WDG_COUNT_W-1:0]; // R15
    end else if (countStep) begin
      nxt_count = count_ff - 12'h001; // R2 R9
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      count_ff <= `WDG_COUNT_RESET; // R9
    end else begin
      count_ff <= nxt_count;
    end
  end

  // ========================================================================
  // chip reset request

  // held until the system reset it causes comes back around
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      chipReset_ff <= 1'b0;
    end else if (fire) begin
      chipReset_ff <= 1'b1; // R10
    end
  end

  assign chipResetRequest = chipReset_ff;

  // ========================================================================
  // triggered flag

  // sits on power-on reset only, so it outlives the reset it reports
  always @(posedge clock or posedge porReset) begin
    if (porReset) begin
      trigFlag_ff <= 1'b0; // R13
    end else if (fire) begin
      trigFlag_ff <= 1'b1; // R12
    end
  end

  // ========================================================================
  // interrupt status and mask

  // set beats a write-one-to-clear arriving in the same cycle
  always @* begin
    nxt_irqStatus = irqStatus_ff;
    if (statusWrite) begin
      nxt_irqStatus = irqStatus_ff & ~pwdata[`WDG_IRQ_W-1:0];
    end
    if (reachZero) begin
      nxt_irqStatus[`WDG_IRQ_ZERO_BIT] = 1'b1;
    end
    if (prescaleStep) begin
      nxt_irqStatus[`WDG_IRQ_WRAP_BIT] = 1'b1;
    end
  end

  // mask takes the low lane whole; no set or clear semantics
  always @* begin
    nxt_irqMask = irqMask_ff;
    if (maskWrite) begin
      nxt_irqMask = pwdata[`WDG_IRQ_W-1:0];
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      irqStatus_ff <= 2'h0;
      irqMask_ff <= `WDG_IRQ_MASK_RESET;
    end else begin
      irqStatus_ff <= nxt_irqStatus;
      irqMask_ff <= nxt_irqMask;
    end
  end

  // level output, high while any unmasked event is pending
  assign irq = |(irqStatus_ff & irqMask_ff);

  // ========================================================================
  // read data

  // captured in the setup cycle, shown during the access cycle;
  // reserved bits and unmapped addresses read zero
  always @* begin
    nxt_prdata = prdata_ff;
    if (setupPhase & ~pwrite) begin
      nxt_prdata = 32'h00000000;
      if (hitControl) begin
        nxt_prdata[`WDG_CTL_RUN_BIT] = ctlRun_ff;
        nxt_prdata[`WDG_CTL_TRIG_BIT] = ctlTrig_ff;
      end
      if (hitValue) begin
        nxt_prdata[15:0] = prescaleValue; // R6
      end
      if (hitLimit) begin
        nxt_prdata[15:0] = limit_ff;
      end
      if (hitCount) begin
        nxt_prdata[11:0] = count_ff;
      end
      if (hitFlag) begin
        nxt_prdata[`WDG_FLAG_BIT] = trigFlag_ff; // R12
      end
      if (hitIrqStatus) begin
        nxt_prdata[1:0] = irqStatus_ff;
      end
      if (hitIrqMask) begin
        nxt_prdata[1:0] = irqMask_ff;
      end
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      prdata_ff <= 32'h00000000;
    end else begin
      prdata_ff <= nxt_prdata;
    end
  end

endmodule

// ---- hw/watchdog_prescaler.v ----
// 16-bit prescaler that wraps at a programmable limit and emits a step
`timescale 1ns/1ps
`include "watchdog_regs.vh"

module watchdog_prescaler (
  input wire clock,
  input wire reset,
  input wire run,
  input wire advance,
  input wire [15:0] limit,
  output wire [15:0] value,
  output wire wrapStep
);

  // ========================================================================
  // counter
  reg [15:0] count_ff;
  reg [15:0] nxt_count;

  // one step per limit+1 edges; a stopped watchdog freezes the count
  assign wrapStep = run & advance & (count_ff == limit); // R7 R8
  assign value = count_ff; // R6

  always @* begin
    nxt_count = count_ff; // R15
    if (wrapStep) begin
      nxt_count = 16'h0000; // R7
    end else if (run & advance) begin
      nxt_count = count_ff + 16'h0001; // R6
    end
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      count_ff <= `WDG_PRESCALE_RESET;
    end else begin
      count_ff <= nxt_count;
    end
  end

endmodule

// ---- hw/watchdog_regs.vh ----
// register indices, field positions, reset values and widths of the watchdog
`ifndef WATCHDOG_REGS_VH
`define WATCHDOG_REGS_VH

// ==========================================================================
// register indices (byte address is four times the index)
`define WDG_IDX_CONTROL 16'hF020
`define WDG_IDX_PRESCALE_VALUE 16'hF021
`define WDG_IDX_PRESCALE_LIMIT 16'hF022
`define WDG_IDX_COUNTDOWN 16'hF023
`define WDG_IDX_TRIGGER_FLAG 16'hF024
`define WDG_IDX_IRQ_STATUS 16'hF025
`define WDG_IDX_IRQ_MASK 16'hF026
`define WDG_ADDR_W 18

// ==========================================================================
// field positions
`define WDG_CTL_RUN_BIT 0
`define WDG_CTL_TRIG_BIT 1
`define WDG_FLAG_BIT 0
`define WDG_IRQ_ZERO_BIT 0
`define WDG_IRQ_WRAP_BIT 1
`define WDG_PRESCALE_W 16
`define WDG_COUNT_W 12
`define WDG_IRQ_W 2

// ==========================================================================
// reset values
`define WDG_CTL_RESET 2'h0
`define WDG_LIMIT_RESET 16'hFFFF
`define WDG_COUNT_RESET 12'hFFF
`define WDG_PRESCALE_RESET 16'h0000
`define WDG_IRQ_MASK_RESET 2'h0

`endif

// ---- tb/oscillator_prescaled_watchdog_assertions.sv ----
// port-level assertions for the oscillator prescaled watchdog
`timescale 1ns/1ps

module oscillator_prescaled_watchdog_checker (
  input wire clock,
  input wire reset,
  input wire porReset,
  input wire crystalInputClock,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [17:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire chipResetRequest,
  input wire irq
);
  // ==========================================================================
  // bus and trigger properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // decode of the access phase and of the word-aligned register window
  wire access = psel && penable;
  wire mapped = paddr >= 18'h3C080 && paddr <= 18'h3C098 && paddr[1:0] == 2'h0;
  wire outside = paddr < 18'h3C080 || paddr > 18'h3C098;

  AST_ZERO_WAIT: assert property (access |-> pready)
    else $error("access phase without ready");
  AST_ERR_ONLY_ACCESS: assert property (pslverr |-> access)
    else $error("error response outside access phase");
  AST_ERR_UNMAPPED: assert property (access && outside |-> pslverr)
    else $error("unmapped access not refused");
  AST_NO_ERR_MAPPED: assert property (access && mapped |-> !pslverr)
    else $error("mapped access refused");
  AST_UNMAPPED_ZERO: assert property (access && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  AST_PRDATA_HOLDS: assert property (access |=> $stable(prdata))
    else $error("read data moved after access");
  AST_RESET_STICKY: assert property (chipResetRequest |=> chipResetRequest)
    else $error("chip reset request dropped");
  AST_QUIET_AFTER_RESET: assert property ($fell(reset) |-> (!chipResetRequest && !irq) [*2])
    else $error("activity right after reset");
  AST_FLAG_VISIBLE: assert property (access && !pwrite && paddr == 18'h3C090 &&
    $past(chipResetRequest) |-> prdata[0])
    else $error("triggered flag not set after firing");
endmodule

bind oscillator_prescaled_watchdog oscillator_prescaled_watchdog_checker
  oscillator_prescaled_watchdog_checker_i (.clock(clock), .reset(reset), .porReset(porReset),
  .crystalInputClock(crystalInputClock), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .chipResetRequest(chipResetRequest), .irq(irq));

// ---- tb/oscillator_prescaled_watchdog_tb.sv ----
// self-checking bench for the oscillator prescaled watchdog
`timescale 1ns/1ps
`include "watchdog_regs.vh"

module oscillator_prescaled_watchdog_tb;
  // ==========================================================================
  // signals and byte addresses
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic porReset = 1'b1;
  logic crystalInputClock = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire chipResetRequest;
  wire irq;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] rdata;
  logic lastErr;
  localparam logic [17:0] CTL = {`WDG_IDX_CONTROL, 2'b00};
  localparam logic [17:0] VAL = {`WDG_IDX_PRESCALE_VALUE, 2'b00};
  localparam logic [17:0] LIM = {`WDG_IDX_PRESCALE_LIMIT, 2'b00};
  localparam logic [17:0] CNT = {`WDG_IDX_COUNTDOWN, 2'b00};
  localparam logic [17:0] FLG = {`WDG_IDX_TRIGGER_FLAG, 2'b00};
  localparam logic [17:0] IST = {`WDG_IDX_IRQ_STATUS, 2'b00};
  localparam logic [17:0] IMK = {`WDG_IDX_IRQ_MASK, 2'b00};

  oscillator_prescaled_watchdog oscillator_prescaled_watchdog_i (.clock(clock), .reset(reset),
    .porReset(porReset), .crystalInputClock(crystalInputClock), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chipResetRequest(chipResetRequest), .irq(irq));

  // 125 MHz system clock
  always #4 clock = ~clock;

  // hang guard: a run past the ceiling counts as a mismatch
  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      num_errors++;
      summarize();
    end
  end

  // ==========================================================================
  // shared tasks
  task automatic summarize();
    if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; an idle edge follows so psel is never reassigned in one step
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rdata = prdata;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [17:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask

  // oscillator edges, slow against the system clock, then let the synchroniser settle
  task automatic xt(input int n);
    repeat (n) begin
      crystalInputClock <= 1'b1;
      repeat (4) @(posedge clock);
      crystalInputClock <= 1'b0;
      repeat (4) @(posedge clock);
    end
    repeat (6) @(posedge clock);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset_values();
    rd(CTL, 32'h0);
    rd(VAL, 32'h0);
    rd(LIM, 32'hFFFF);
    rd(CNT, 32'hFFF);
    rd(FLG, 32'h0);
    rd(18'h3C0A0, 32'h0);
    chk({31'h0, lastErr}, 32'h1);
    wr(VAL, 32'hFFFF);
    rd(VAL, 32'h0);
    wr(FLG, 32'h1);
    rd(FLG, 32'h0);
  endtask

  // limit 3 divides by four: ten edges give two steps and leave the prescaler at 2
  task automatic t_count();
    wr(LIM, 32'h3);
    wr(CNT, 32'h5);
    wr(CTL, 32'h1);
    xt(10);
    rd(CNT, 32'h3);
    rd(VAL, 32'h2);
    wr(CTL, 32'h0);
    xt(3);
    rd(VAL, 32'h2);
    rd(CNT, 32'h3);
  endtask

  task automatic t_count_only();
    wr(CNT, 32'h1);
    wr(CTL, 32'h1);
    xt(8);
    rd(CNT, 32'h0);
    rd(VAL, 32'h2);
    chk({31'h0, chipResetRequest}, 32'h0);
    wr(CTL, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(IMK, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(IST, 32'h2);
    chk({31'h0, irq}, 32'h0);
    wr(IMK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(IST, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(IMK, 32'h0);
    wr(CNT, 32'h7);
    rd(CNT, 32'h7);
  endtask

  task automatic t_trigger();
    wr(CNT, 32'h2);
    wr(CTL, 32'h3);
    xt(5);
    wr(CNT, 32'h2);
    xt(4);
    chk({31'h0, chipResetRequest}, 32'h0);
    xt(1);
    chk({31'h0, chipResetRequest}, 32'h1);
    rd(FLG, 32'h1);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    chk({31'h0, chipResetRequest}, 32'h0);
    rd(FLG, 32'h1);
    rd(CTL, 32'h0);
    porReset <= 1'b1;
    @(posedge clock);
    porReset <= 1'b0;
    @(posedge clock);
    rd(FLG, 32'h0);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    porReset <= 1'b0;
    @(posedge clock);
    t_reset_values();
    t_count();
    t_count_only();
    t_trigger();
    summarize();
  end
endmodule
